// [pwm_adc_trigger_sequencer.sv]
`timescale 1ns/1ps
// Behaviour
// R01 - The PWM timer emits a cycle-start pulse at the start of each period, opening a loop cycle.
// R02 - Each cycle-start pulse restarts both delay units and loads their buffered settings.
// R03 - A delay unit starts its converter's first channel when its count meets the first delay.
// R04 - Conversion instants sit at the same offsets from cycle start in every loop cycle.
// R05 - Delay unit B converts the DC bus voltage first, at the very start of the PWM cycle.
// R06 - Both phase currents are launched together at mid-cycle while the low switches conduct.
// R07 - Delay unit A launches phase A on its first delay; unit B launches phase B on its second.
// R08 - Each result is written to a fixed result queue without processor help.
// R09 - The end of converter B's sequence raises a conversion-complete interrupt.
// R10 - Software writes new duties; the timer applies them only from the next period.
// R11 - The completion handler disables the cycle-start output for the next period.
// R12 - Unit B's handler re-enables the cycle-start output after that period's chance has passed.
// R13 - After a pre-trigger fires its lock stays set until the done flag sets; no trigger before.
// R14 - On a trigger the converter converts channels in the order the pre-triggers set.
// R15 - Each delay unit counts in its own clock cycles from zero at the restart.
module pwm_adc_trigger_sequencer
  import trig_seq_pkg::*;
#(
  parameter int W = CNT_W,
  parameter int DEPTH = QUEUE_DEPTH,
  parameter int RES_W = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Timer settings from software
  input wire logic [W-1:0] periodIn,
  input wire logic [W-1:0] dutyIn,
  input wire logic dutyWrite,
  input wire logic cycleStartEnable,
  // Delay settings, taken at each cycle start
  input wire logic [W-1:0] busDelay,
  input wire logic [W-1:0] midDelay,
  // Converter A (phase A current)
  input wire logic convADone,
  input wire logic [RES_W-1:0] convAResult,
  // Converter B (bus voltage then phase B current)
  input wire logic convBDone,
  input wire logic [RES_W-1:0] convBResult,
  // Queue read port
  input wire logic [1:0] queueSel,
  output logic [RES_W-1:0] queueData,
  // Timer and trigger outputs
  output logic pwmOut,
  output logic cycleStart,
  output logic convAStart,
  output logic convBStart,
  output logic convBSecond,
  output logic convCompleteIrq,
  output logic delayBIrq
);
  logic [W-1:0] pwmCnt_q, pwmCnt_d;
  logic [W-1:0] period_q, period_d;
  logic [W-1:0] dutyAct_q, dutyAct_d;
  logic [W-1:0] dutyBuf_q, dutyBuf_d;
  logic pwm_q, pwm_d;
  logic start_q, start_d;
  logic aStart_q, aStart_d;
  logic bStart_q, bStart_d;
  logic bSec_q, bSec_d;
  logic irq_q, irq_d;
  logic bIrq_q, bIrq_d;
  logic bSeqSecond_q, bSeqSecond_d;
  logic [RES_W-1:0] queue_q [DEPTH];
  logic [RES_W-1:0] qData_q;
  logic [RES_W-1:0] qData_d;
  logic aFirst;
  logic aSecond;
  logic bFirst;
  logic bSecond;
  logic periodEnd;

  initial begin
    if (DEPTH != 4) $error("queue depth must be 4");
    if (W < 4) $error("counter width too small");
  end

  // Sequence position helper: last count of the period
  function automatic logic isLast(input logic [W-1:0] c, input logic [W-1:0] p);
    return (c >= p - W'(1));
  endfunction

  assign periodEnd = isLast(pwmCnt_q, period_q);

  // PWM timer: counter, period and duty buffering
  always_comb begin
    pwmCnt_d = pwmCnt_q + W'(1);
    period_d = period_q;
    dutyAct_d = dutyAct_q;
    dutyBuf_d = dutyBuf_q;
    start_d = 1'b0;
    // R10 buffer software duty
    if (dutyWrite) dutyBuf_d = dutyIn;
    if (periodEnd) begin
      pwmCnt_d = '0;
      // R10 apply at next period
      dutyAct_d = dutyWrite ? dutyIn : dutyBuf_q;
      period_d = (periodIn < 16'h0004) ? 16'h0004 : periodIn;
      // R01 cycle-start pulse
      // R11 gated by software enable
      start_d = cycleStartEnable;
    end
    // Centre-aligned output: high around mid-period, low switches on near middle
    pwm_d = (pwmCnt_d < (period_q >> 1)) ? (pwmCnt_d >= ((period_q >> 1) - (dutyAct_q >> 1)))
          : (pwmCnt_d < ((period_q >> 1) + (dutyAct_q >> 1)));
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwmCnt_q <= CNT_RST;
      period_q <= PERIOD_RST;
      dutyAct_q <= DUTY_RST;
      dutyBuf_q <= DUTY_RST;
      pwm_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      pwmCnt_q <= pwmCnt_d;
      period_q <= period_d;
      dutyAct_q <= dutyAct_d;
      dutyBuf_q <= dutyBuf_d;
      pwm_q <= pwm_d;
      start_q <= start_d;
    end
  end

  // R02 restart both units
  // R04 same offsets each cycle
  // R07 unit A first delay is mid-cycle, phase A
  delay_unit #(.W(W)) unitA (
    .clk(clk),
    .rst_b(rst_b),
    .restart(start_q),
    .firstDelayIn(midDelay),
    .secondDelayIn(midDelay),
    .secondEn(1'b0),
    .convDone(convADone),
    .firstFire(aFirst),
    .secondFire(aSecond),
    .locked()
  );

  // R05 unit B bus voltage first
  // R06 phase B at mid-cycle with phase A
  delay_unit #(.W(W)) unitB (
    .clk(clk),
    .rst_b(rst_b),
    .restart(start_q),
    .firstDelayIn(busDelay),
    .secondDelayIn(midDelay),
    .secondEn(1'b1),
    .convDone(convBDone),
    .firstFire(bFirst),
    .secondFire(bSecond),
    .locked()
  );

  // Trigger pulses, completion interrupt and unit B period event
  always_comb begin
    aStart_d = aFirst | aSecond;
    bStart_d = bFirst | bSecond;
    bSec_d = bSecond;
    bSeqSecond_d = bSeqSecond_q;
    if (bFirst) bSeqSecond_d = 1'b0;
    if (bSecond) bSeqSecond_d = 1'b1;
    // R09 done after phase B result
    irq_d = convBDone && bSeqSecond_q;
    // Unit B event once the trigger chance of the idle period has passed
    // R12 re-enable point for software
    bIrq_d = periodEnd && !cycleStartEnable;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aStart_q <= 1'b0;
      bStart_q <= 1'b0;
      bSec_q <= 1'b0;
      bSeqSecond_q <= 1'b0;
      irq_q <= 1'b0;
      bIrq_q <= 1'b0;
    end else begin
      aStart_q <= aStart_d;
      bStart_q <= bStart_d;
      bSec_q <= bSec_d;
      bSeqSecond_q <= bSeqSecond_d;
      irq_q <= irq_d;
      bIrq_q <= bIrq_d;
    end
  end

  // Result queue: slot 0 phase A, 1 bus voltage, 2 phase B, 3 spare
  // R08 automatic result store
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        queue_q[i] <= '0;
      end
    end else begin
      if (convADone) queue_q[0] <= convAResult;
      if (convBDone && !bSeqSecond_q) queue_q[1] <= convBResult;
      if (convBDone && bSeqSecond_q) queue_q[2] <= convBResult;
    end
  end

  // Queue read mux, registered
  always_comb begin
    qData_d = queue_q[queueSel];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      qData_q <= '0;
    end else begin
      qData_q <= qData_d;
    end
  end

  assign queueData = qData_q;
  assign pwmOut = pwm_q;
  assign cycleStart = start_q;
  assign convAStart = aStart_q;
  assign convBStart = bStart_q;
  assign convBSecond = bSec_q;
  assign convCompleteIrq = irq_q;
  assign delayBIrq = bIrq_q;
endmodule

// [trig_seq_pkg.sv]
package trig_seq_pkg;
  localparam int CNT_W = 16;
  // PWM period in clocks (up counter, full period)
  localparam logic [CNT_W-1:0] PERIOD_RST = 16'h00c8;
  // Sample delays after reset, in clocks from cycle start
  localparam logic [CNT_W-1:0] BUS_DELAY_RST = 16'h0000;
  localparam logic [CNT_W-1:0] MID_DELAY_RST = 16'h0064;
  localparam logic [CNT_W-1:0] DUTY_RST = 16'h0064;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam int QUEUE_DEPTH = 4;
  localparam logic [1:0] QPTR_RST = 2'h0;
endpackage

// [delay_unit.sv]
`timescale 1ns/1ps
module delay_unit
  import trig_seq_pkg::*;
#(
  parameter int W = CNT_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Restart from cycle start
  input wire logic restart,
  // Buffered settings
  input wire logic [W-1:0] firstDelayIn,
  input wire logic [W-1:0] secondDelayIn,
  input wire logic secondEn,
  // Converter side
  input wire logic convDone,
  output logic firstFire,
  output logic secondFire,
  output logic locked
);
  logic [W-1:0] cnt_q, cnt_d;
  logic [W-1:0] first_q, first_d;
  logic [W-1:0] second_q, second_d;
  logic run_q, run_d;
  logic lock_q, lock_d;
  logic [1:0] pend_q, pend_d;

  initial begin
    if (W < 2) $error("delay_unit width too small");
  end

  // Next-state: counter, active copies, lock
  always_comb begin
    cnt_d = cnt_q;
    first_d = first_q;
    second_d = second_q;
    run_d = run_q;
    lock_d = lock_q;
    pend_d = pend_q;
    firstFire = 1'b0;
    secondFire = 1'b0;
    // R13 lock release on done
    if (convDone) lock_d = 1'b0;
    if (restart) begin
      // R02 restart and load
      // R15 count from zero
      cnt_d = '0;
      first_d = firstDelayIn;
      second_d = secondDelayIn;
      run_d = 1'b1;
      pend_d = {secondEn, 1'b1};
    end else if (run_q) begin
      // Pre-trigger once the count reaches or passes its delay; a locked one waits for the done flag
      // R03 first delay match
      // R14 order by pretriggers
      if (pend_q[0] && cnt_q >= first_q && !lock_q) begin
        firstFire = 1'b1;
        pend_d[0] = 1'b0;
        lock_d = 1'b1;
      // R13 no trigger while locked
      end else if (!pend_q[0] && pend_q[1] && cnt_q >= second_q && !lock_q) begin
        secondFire = 1'b1;
        pend_d[1] = 1'b0;
        lock_d = 1'b1;
      end
      if (pend_d == 2'b00) run_d = 1'b0;
      if (cnt_q != {W{1'b1}}) cnt_d = cnt_q + W'(1);
    end
  end

  assign locked = lock_q;

  // Register state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= CNT_RST;
      first_q <= CNT_RST;
      second_q <= CNT_RST;
      run_q <= 1'b0;
      lock_q <= 1'b0;
      pend_q <= 2'b00;
    end else begin
      cnt_q <= cnt_d;
      first_q <= first_d;
      second_q <= second_d;
      run_q <= run_d;
      lock_q <= lock_d;
      pend_q <= pend_d;
    end
  end
endmodule

// [trig_seq_properties.sv]
`timescale 1ns/1ps
module trig_seq_checker #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Watched inputs
  input wire logic [W-1:0] periodIn,
  input wire logic cycleStartEnable,
  input wire logic convADone,
  input wire logic convBDone,
  // Watched outputs
  input wire logic cycleStart,
  input wire logic convAStart,
  input wire logic convBStart,
  input wire logic convBSecond,
  input wire logic convCompleteIrq,
  input wire logic delayBIrq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic lockA_q, lockB_q, secB_q, seen_q;
  logic [W-1:0] cnt_q;
  // Shadow locks and period count; a done frees its lock from the cycle after it arrives
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lockA_q <= 1'b0;
      lockB_q <= 1'b0;
      secB_q <= 1'b0;
      seen_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      lockA_q <= convAStart | (lockA_q & ~convADone);
      lockB_q <= convBStart | (lockB_q & ~convBDone);
      secB_q <= (convBStart & convBSecond) | (secB_q & ~convBDone);
      seen_q <= seen_q | cycleStart;
      cnt_q <= (cycleStart | delayBIrq) ? '0 : cnt_q + W'(1);
    end
  end
  chk_start_single: assert property (cycleStart |=> !cycleStart)
    else $error("cycle start longer than one clock");
  chk_period_exact: assert property ((cycleStart || delayBIrq) && seen_q |->
    cnt_q == periodIn - W'(1)) else $error("period length wrong");
  chk_start_gated: assert property (cycleStart |-> $past(cycleStartEnable))
    else $error("cycle start while disabled");
  chk_skip_event: assert property (delayBIrq |-> !cycleStart && !$past(cycleStartEnable))
    else $error("skip event wrong");
  chk_bus_first: assert property (convBStart && !convBSecond |-> $past(cycleStart, 2))
    else $error("bus start not at cycle start");
  chk_mid_pair: assert property (convAStart && !lockB_q |-> convBStart && convBSecond)
    else $error("phase starts not together");
  chk_second_on_b: assert property (convBSecond |-> convBStart)
    else $error("second flag without start");
  chk_lock_a: assert property (convAStart |-> !lockA_q)
    else $error("unit A fired while locked");
  chk_lock_b: assert property (convBStart |-> !lockB_q)
    else $error("unit B fired while locked");
  chk_irq_raise: assert property (convBDone && secB_q |=> convCompleteIrq)
    else $error("complete irq missing");
  chk_irq_cause: assert property (convCompleteIrq |-> $past(convBDone))
    else $error("complete irq without done");
endmodule

// [conv_model.sv]
`timescale 1ns/1ps
module conv_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Trigger side
  input wire logic start,
  input wire logic [7:0] lat,
  input wire logic [11:0] val,
  // Result side
  output logic done,
  output logic [11:0] res
);
  logic [7:0] cnt;
  logic [11:0] held;
  // one conversion at a time, in trigger order; lat must be at least 1
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 8'h00;
      done <= 1'b0;
      held <= 12'h000;
    end else begin
      done <= (cnt == 8'h01);
      if (start && cnt == 8'h00) begin
        cnt <= lat;
        held <= val;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
  // Result is junk outside the done cycle, so a late read cannot pass
  assign res = done ? held : ~held;
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import trig_seq_pkg::*;
  logic clk, rst_b, dutyWrite, en, aDone, bDone, pwm, cs, aSt, bSt, bSec, irq, dIrq;
  logic [CNT_W-1:0] dutyIn, midDelay;
  logic [11:0] aRes, bRes, qData;
  logic [11:0] expQ [4] = '{12'h0a5, 12'h1b1, 12'h2b2, 12'h000};
  logic [7:0] latB;
  logic [1:0] qSel;
  logic [2:0] ev;
  int n_mismatch, cmp_count, cyc, nCs, hi, lastHi;
  assign ev = {bSec, dIrq, cs};
  // Design; period 40 clocks keeps each test short
  pwm_adc_trigger_sequencer i_dut (.clk, .rst_b, .periodIn(16'h0028), .dutyIn, .dutyWrite,
    .cycleStartEnable(en), .busDelay(16'h0000), .midDelay, .convADone(aDone),
    .convAResult(aRes), .convBDone(bDone), .convBResult(bRes), .queueSel(qSel),
    .queueData(qData), .pwmOut(pwm), .cycleStart(cs), .convAStart(aSt), .convBStart(bSt),
    .convBSecond(bSec), .convCompleteIrq(irq), .delayBIrq(dIrq));
  // Converters; B tells bus from phase by the second flag
  conv_model i_convA (.clk, .rst_b, .start(aSt), .lat(8'h03), .val(12'h0a5), .done(aDone),
    .res(aRes));
  conv_model i_convB (.clk, .rst_b, .start(bSt), .lat(latB), .val(bSec ? 12'h2b2 : 12'h1b1),
    .done(bDone), .res(bRes));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Cycle count, cycle starts, PWM high time per period, hang guard
  always @(posedge clk) begin
    cyc++;
    if (cs === 1'b1) begin
      nCs++;
      lastHi = hi;
      hi = 0;
    end
    if (pwm === 1'b1) hi++;
    if (cyc == 5000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic check(input logic ok, input string m);
    cmp_count++;
    if (!ok) begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic waitEv(input int k, output int n);
    n = 0;
    do begin
      step(1);
      n++;
    end while (ev[k] !== 1'b1 && n < 300);
    check(ev[k] === 1'b1, "event missing");
  endtask
  task automatic t_frame(input int mid, input logic [15:0] nxt);
    int n;
    waitEv(0, n);
    step(2);
    // New delay goes in after the restart load, so it only counts from the next frame
    midDelay = nxt;
    check(bSt === 1'b1 && bSec === 1'b0 && aSt === 1'b0, "bus start");
    step(mid);
    check(aSt === 1'b1 && bSt === 1'b1 && bSec === 1'b1, "mid starts");
    step(5);
    check(irq === 1'b1, "complete irq");
    for (int s = 0; s < 4; s++) begin
      qSel = 2'(s);
      step(1);
      check(qData === expQ[s], "queue slot");
    end
  endtask
  task automatic t_lock();
    int n;
    latB = 8'h1e;
    waitEv(0, n);
    step(3);
    latB = 8'h03;
    step(19);
    check(aSt === 1'b1 && bSt === 1'b0, "lock holds");
    waitEv(2, n);
    check(n === 13, "late second");
  endtask
  task automatic t_gate();
    int n, c;
    t_frame(20, 16'h0014);
    en = 1'b0;
    c = nCs;
    waitEv(1, n);
    check(nCs === c, "start not gated");
    en = 1'b1;
    waitEv(0, n);
    check(n === 40, "restart spacing");
  endtask
  task automatic t_duty();
    int n, h0, h1;
    waitEv(0, n);
    step(5);
    dutyIn = 16'h000a;
    dutyWrite = 1'b1;
    h0 = lastHi;
    step(1);
    dutyWrite = 1'b0;
    waitEv(0, n);
    step(1);
    h1 = lastHi;
    check((h1 - h0) * (h1 - h0) <= 1, "duty changed mid period");
    waitEv(0, n);
    step(1);
    check((h1 - lastHi) * (h1 - lastHi) > 16, "duty not applied");
  endtask
  task automatic final_report();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    en = 1'b1;
    dutyWrite = 1'b0;
    dutyIn = 16'h001e;
    midDelay = 16'h0014;
    latB = 8'h03;
    qSel = 2'h0;
    repeat (2) @(posedge clk);
    #1;
    check({pwm, cs, aSt, bSt, bSec, irq, dIrq} === 7'h00, "outputs in reset");
    rst_b = 1'b1;
    step(1);
    dutyWrite = 1'b1;
    step(1);
    dutyWrite = 1'b0;
    t_frame(20, 16'h0014);
    t_frame(20, 16'h0018);
    t_frame(24, 16'h0014);
    t_lock();
    t_gate();
    t_duty();
    final_report();
  end
endmodule
bind pwm_adc_trigger_sequencer trig_seq_checker #(.W(W)) i_chk (.clk, .rst_b, .periodIn,
  .cycleStartEnable, .convADone, .convBDone, .cycleStart, .convAStart, .convBStart,
  .convBSecond, .convCompleteIrq, .delayBIrq);
